// [hw/lsc_pkg.sv]
package lsc_pkg;

  // Register offsets
  localparam logic [11:0] LSC_LINK_OFS = 12'h0d0;
  localparam logic [11:0] LSC_SLOT_OFS = 12'h0d4;

  // Link status field positions
  localparam int LSC_SPEED_LSB = 16;
  localparam int LSC_WIDTH_LSB = 20;
  localparam int LSC_TERR_BIT = 26;
  localparam int LSC_TRN_BIT = 27;
  localparam int LSC_SCLK_BIT = 28;
  localparam int LSC_DLA_BIT = 29;
  localparam int LSC_BWM_BIT = 30;
  localparam int LSC_BWA_BIT = 31;
  localparam int LSC_W1C_LANE = 3;

  // Field widths
  localparam int LSC_SPEED_W = 4;
  localparam int LSC_WIDTH_W = 6;
  localparam int LSC_CAP_W = 7;

  // Codes and reset values
  localparam logic [3:0] LSC_SPEED_2G5 = 4'h1;
  localparam logic [3:0] LSC_SPEED_5G0 = 4'h2;
  localparam logic [3:0] LSC_SPEED_RST = LSC_SPEED_5G0;
  localparam logic [5:0] LSC_WIDTH_RST = 6'h01;
  localparam logic [5:0] LSC_WIDTH_NONE = 6'h00;
  localparam logic LSC_TERR_RST = 1'b0;
  localparam logic LSC_TRN_RST = 1'b1;
  localparam logic LSC_SCLK_RST = 1'b1;
  localparam logic LSC_DLA_RST = 1'b0;
  localparam logic LSC_BW_RST = 1'b0;
  // Slot caps: button, power ctl, latch sensor, attn ind, power ind, surprise, hot-plug
  localparam logic [6:0] LSC_CAP_RST = 7'h5f;
  localparam logic [31:0] LSC_ZERO_WORD = 32'h0000_0000;

  // Register select
  typedef enum logic [1:0] {
    LSC_SEL_NONE,
    LSC_SEL_LINK,
    LSC_SEL_SLOT
  } lsc_sel_type;

  // Link layer status from the port core
  typedef struct packed {
    logic [3:0] speed;
    logic [5:0] width;
    logic train_fail;
    logic train_ok;
    logic train_busy;
    logic dl_active;
    logic bw_mgmt_evt;
    logic bw_auto_evt;
  } lsc_link_evt_type;

  function automatic lsc_sel_type lsc_decode(input logic [11:0] addr);
    lsc_decode = (addr == LSC_LINK_OFS) ? LSC_SEL_LINK :
                 (addr == LSC_SLOT_OFS) ? LSC_SEL_SLOT : LSC_SEL_NONE;
  endfunction

endpackage

// [hw/lsc_pin_sync.sv]
`timescale 1ns/10ps
module lsc_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pin and clean level
  input wire logic pin,
  output logic level
);

  logic s1_r, s2_r, s3_r, lvl_r;
  logic lvl_nxt;

  always_comb begin
    lvl_nxt = lvl_r;
    if (s2_r == s3_r) begin
      lvl_nxt = s3_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      lvl_r <= RST_VAL;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;

endmodule

// [hw/lsc_flag.sv]
`timescale 1ns/10ps
module lsc_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Set wins over clear
  input wire logic set,
  input wire logic clr,
  output logic q
);

  logic q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (set) begin
      q_nxt = 1'b1;
    end else if (clr) begin
      q_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// [hw/lsc_port_status.sv]
// Summary of operation
// - Link speed field reports negotiated rate, codes 1 or 2, resets to 2.
// - Six-bit negotiated width field, resets to one lane.
// - Training error flag sets when link training fails; resets zero.
// - Training error clears by hardware on successful training to L0.
// - Link training flag set while training runs; reads one after reset.
// - Link training flag clears once training completes.
// - Slot clock bit: one shares connector reference, zero independent; resets one.
// - Link active bit is one only in DL_Active, resets zero.
// - Slot capability register exists only on downstream ports.
// - Attention button present bit, resets one.
// - Power controller present bit, resets one.
// - Retention latch sensor present bit, resets one.
// - Attention indicator present bit, resets one.
// - Power indicator present bit, resets one.
// - Surprise removal bit, resets zero.
// - Hot-plug capable bit.
// - Preload may override slot clock and slot capability defaults.
//
`timescale 1ns/10ps
module lsc_port_status (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Port role strap pin
  input wire logic downstream_pin,
  // Link layer status
  input wire lsc_pkg::lsc_link_evt_type link_evt,
  // Default preload
  input wire logic preload_wr,
  input wire logic [11:0] preload_addr,
  input wire logic [31:0] preload_data,
  // Configuration access
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid
);
  import lsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic downstream;
  logic terr, bwm, bwa;
  logic bwm_clr, bwa_clr;
  logic [3:0] speed_r, speed_nxt;
  logic [5:0] width_r, width_nxt;
  logic trn_r, trn_nxt;
  logic dla_r, dla_nxt;
  logic sclk_r, sclk_nxt;
  logic [6:0] cap_r, cap_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] link_word;
  lsc_sel_type cfg_sel, pre_sel;
  logic speed_legal;

  ////////////////////////////////////////////////////////////////////////////
  // Strap and sticky flags

  lsc_pin_sync #(.RST_VAL(1'b0)) u_role_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin(downstream_pin),
    .level(downstream)
  );

  lsc_flag #(.RST_VAL(LSC_TERR_RST)) u_terr (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .set(link_evt.train_fail),
    .clr(link_evt.train_ok),
    .q(terr)
  );

  lsc_flag #(.RST_VAL(LSC_BW_RST)) u_bwm (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .set(link_evt.bw_mgmt_evt),
    .clr(bwm_clr),
    .q(bwm)
  );

  lsc_flag #(.RST_VAL(LSC_BW_RST)) u_bwa (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .set(link_evt.bw_auto_evt),
    .clr(bwa_clr),
    .q(bwa)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  assign cfg_sel = lsc_decode(cfg_addr);
  assign pre_sel = lsc_decode(preload_addr);
  assign speed_legal = (link_evt.speed == LSC_SPEED_2G5) || (link_evt.speed == LSC_SPEED_5G0);

  // Write one clears, byte lane must be enabled
  assign bwm_clr = cfg_wr && (cfg_sel == LSC_SEL_LINK) && cfg_be[LSC_W1C_LANE]
                   && cfg_wdata[LSC_BWM_BIT];
  assign bwa_clr = cfg_wr && (cfg_sel == LSC_SEL_LINK) && cfg_be[LSC_W1C_LANE]
                   && cfg_wdata[LSC_BWA_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Link status and capability fields

  always_comb begin
    speed_nxt = speed_r;
    width_nxt = width_r;
    sclk_nxt = sclk_r;
    cap_nxt = cap_r;
    if (link_evt.train_ok && speed_legal) begin
      speed_nxt = link_evt.speed;
    end
    if (link_evt.train_ok && (link_evt.width != LSC_WIDTH_NONE)) begin
      width_nxt = link_evt.width;
    end
    trn_nxt = link_evt.train_busy;
    dla_nxt = link_evt.dl_active;
    if (preload_wr && (pre_sel == LSC_SEL_LINK)) begin
      sclk_nxt = preload_data[LSC_SCLK_BIT];
    end
    if (preload_wr && (pre_sel == LSC_SEL_SLOT)) begin
      cap_nxt = preload_data[LSC_CAP_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_r <= LSC_SPEED_RST;
      width_r <= LSC_WIDTH_RST;
      trn_r <= LSC_TRN_RST;
      dla_r <= LSC_DLA_RST;
      sclk_r <= LSC_SCLK_RST;
      cap_r <= LSC_CAP_RST;
    end else begin
      speed_r <= speed_nxt;
      width_r <= width_nxt;
      trn_r <= trn_nxt;
      dla_r <= dla_nxt;
      sclk_r <= sclk_nxt;
      cap_r <= cap_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  assign link_word = {bwa, bwm, dla_r, sclk_r, trn_r, terr, width_r, speed_r, 16'h0000};

  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = cfg_rd;
    if (cfg_rd) begin
      case (cfg_sel)
        LSC_SEL_LINK: begin
          rdata_nxt = link_word;
        end
        LSC_SEL_SLOT: begin
          rdata_nxt = downstream ? {25'h0, cap_r} : LSC_ZERO_WORD;
        end
        default: begin
          rdata_nxt = LSC_ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= LSC_ZERO_WORD;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rd_valid = rvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  property p_speed_legal;
    (speed_r == LSC_SPEED_2G5) || (speed_r == LSC_SPEED_5G0);
  endproperty
  a_speed_legal: assert property (p_speed_legal) else $error("speed code illegal");

  property p_speed_read;
    link_evt.train_ok && speed_legal ##1 cfg_rd && (cfg_sel == LSC_SEL_LINK)
      |=> cfg_rdata[LSC_SPEED_LSB +: LSC_SPEED_W] == $past(link_evt.speed, 2);
  endproperty
  a_speed_read: assert property (p_speed_read) else $error("speed not reported");

  property p_width_upd;
    link_evt.train_ok && (link_evt.width != LSC_WIDTH_NONE)
      |=> width_r == $past(link_evt.width);
  endproperty
  a_width_upd: assert property (p_width_upd) else $error("width not taken");

  property p_terr_set;
    link_evt.train_fail |=> terr ##1 (terr || $past(link_evt.train_ok));
  endproperty
  a_terr_set: assert property (p_terr_set) else $error("training error not set");

  property p_terr_clr;
    link_evt.train_ok && !link_evt.train_fail |=> !terr;
  endproperty
  a_terr_clr: assert property (p_terr_clr) else $error("training error not cleared");

  property p_trn_follow;
    link_evt.train_busy [*2] |=> trn_r;
  endproperty
  a_trn_follow: assert property (p_trn_follow) else $error("training flag low");

  property p_trn_done;
    $fell(link_evt.train_busy) |=> !trn_r;
  endproperty
  a_trn_done: assert property (p_trn_done) else $error("training flag stuck");

  property p_sclk_load;
    preload_wr && (pre_sel == LSC_SEL_LINK) |=> sclk_r == $past(preload_data[LSC_SCLK_BIT]);
  endproperty
  a_sclk_load: assert property (p_sclk_load) else $error("slot clock preload lost");

  property p_dla;
    ##1 (dla_r == $past(link_evt.dl_active));
  endproperty
  a_dla: assert property (p_dla) else $error("link active bit wrong");

  property p_upstream_slot;
    cfg_rd && (cfg_sel == LSC_SEL_SLOT) && !downstream |=> cfg_rdata == LSC_ZERO_WORD;
  endproperty
  a_upstream_slot: assert property (p_upstream_slot) else $error("slot caps on upstream");

  property p_cap_read;
    cfg_rd && (cfg_sel == LSC_SEL_SLOT) && downstream
      |=> cfg_rdata[LSC_CAP_W-1:0] == $past(cap_r) && cfg_rd_valid;
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("slot caps read wrong");

  property p_ro_hold;
    cfg_wr && !preload_wr |=> $stable(cap_r) && $stable(sclk_r);
  endproperty
  a_ro_hold: assert property (p_ro_hold) else $error("read-only field written");

  property p_bw_clear;
    bwm_clr && !link_evt.bw_mgmt_evt |=> !bwm;
  endproperty
  a_bw_clear: assert property (p_bw_clear) else $error("bandwidth bit not cleared");

  property p_bw_set_wins;
    link_evt.bw_auto_evt |=> bwa;
  endproperty
  a_bw_set_wins: assert property (p_bw_set_wins) else $error("bandwidth event lost");

  property p_bwm_set_wins;
    link_evt.bw_mgmt_evt |=> bwm;
  endproperty
  a_bwm_set_wins: assert property (p_bwm_set_wins) else $error("management event lost");

  property p_bwa_clear;
    bwa_clr && !link_evt.bw_auto_evt |=> !bwa;
  endproperty
  a_bwa_clear: assert property (p_bwa_clear) else $error("autonomous bit not cleared");

  property p_speed_hold;
    link_evt.train_ok && !speed_legal |=> $stable(speed_r);
  endproperty
  a_speed_hold: assert property (p_speed_hold) else $error("illegal speed taken");

  property p_width_hold;
    link_evt.train_ok && (link_evt.width == LSC_WIDTH_NONE) |=> $stable(width_r);
  endproperty
  a_width_hold: assert property (p_width_hold) else $error("zero width taken");

  property p_trn_read;
    cfg_rd && (cfg_sel == LSC_SEL_LINK) |=> cfg_rdata[LSC_TRN_BIT] == $past(trn_r);
  endproperty
  a_trn_read: assert property (p_trn_read) else $error("training flag read wrong");

  property p_sclk_read;
    cfg_rd && (cfg_sel == LSC_SEL_LINK) |=> cfg_rdata[LSC_SCLK_BIT] == $past(sclk_r);
  endproperty
  a_sclk_read: assert property (p_sclk_read) else $error("slot clock read wrong");

  property p_dla_read;
    cfg_rd && (cfg_sel == LSC_SEL_LINK) |=> cfg_rdata[LSC_DLA_BIT] == $past(dla_r);
  endproperty
  a_dla_read: assert property (p_dla_read) else $error("link active read wrong");

  c_train_cycle: cover property (link_evt.train_busy ##[1:20] link_evt.train_ok);
  c_terr_recover: cover property (terr ##[1:50] !terr);
  c_slot_read: cover property (cfg_rd && (cfg_sel == LSC_SEL_SLOT) && downstream);
  c_bw_w1c: cover property (bwm ##1 bwm_clr);
  c_role_hide: cover property (cfg_rd && (cfg_sel == LSC_SEL_SLOT) && !downstream);

endmodule

// [verification/lsc_port_status_tb_top.sv]
`timescale 1ns/10ps
module lsc_port_status_tb_top;
  import lsc_pkg::*;
  logic sys_clk, rst_b, downstream_pin, preload_wr, cfg_rd, cfg_wr, cfg_rd_valid;
  logic [11:0] preload_addr, cfg_addr;
  logic [31:0] preload_data, cfg_wdata, cfg_rdata, exp_w, rnd_r;
  logic [3:0] cfg_be;
  lsc_link_evt_type link_evt;
  logic [31:0] exp_q[$];
  int fails, n_checks, cyc;
  // Expected register state
  logic [3:0] sp;
  logic [5:0] wd;
  logic terr, trn, sclk, dla, bwm, bwa;
  logic [6:0] cap;

  lsc_port_status u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .downstream_pin(downstream_pin),
    .link_evt(link_evt), .preload_wr(preload_wr), .preload_addr(preload_addr),
    .preload_data(preload_data), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rd_valid(cfg_rd_valid));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [31:0] lw();
    return {bwa, bwm, dla, sclk, trn, terr, wd, sp, 16'h0000};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic idle();
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b0;
    preload_wr <= 1'b0;
    link_evt.train_fail <= 1'b0;
    link_evt.train_ok <= 1'b0;
    link_evt.bw_mgmt_evt <= 1'b0;
    link_evt.bw_auto_evt <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    exp_q.push_back(e);
    tick(1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    tick(1);
    idle();
  endtask

  task automatic pl(input logic [11:0] a, input logic [31:0] d);
    preload_wr <= 1'b1;
    preload_addr <= a;
    preload_data <= d;
    tick(1);
    idle();
  endtask

  task automatic ev(input logic f, input logic o, input logic [3:0] s, input logic [5:0] w);
    cfg_rd <= 1'b0;
    link_evt.train_fail <= f;
    link_evt.train_ok <= o;
    link_evt.speed <= s;
    link_evt.width <= w;
    tick(1);
    idle();
  endtask

  task automatic done(input string name);
    tick(3);
    $display("test %s done", name);
  endtask

  task automatic reset_chk();
    rst_b <= 1'b0;
    link_evt.train_busy <= 1'b1;
    link_evt.dl_active <= 1'b0;
    tick(5);
    rst_b <= 1'b1;
    sp = 4'h2;
    wd = 6'h01;
    terr = 1'b0;
    trn = 1'b1;
    sclk = 1'b1;
    dla = 1'b0;
    bwm = 1'b0;
    bwa = 1'b0;
    cap = 7'h5f;
    tick(6);
    rd(12'h0d0, lw());
    rd(12'h0d4, {25'h0, cap});
    rd(12'h0d8, 32'h0000_0000);
    idle();
    done("reset");
  endtask

  task automatic stop_test();
    if (exp_q.size() != 0) begin
      fails++;
      $display("ERROR exp_q expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Read data checker
  always @(posedge sys_clk) begin
    if (cfg_rd_valid === 1'b1) begin
      n_checks++;
      if (exp_q.size() == 0) begin
        fails++;
        $display("ERROR cfg_rdata expected none seen %h", cfg_rdata);
      end else begin
        exp_w = exp_q.pop_front();
        if (cfg_rdata !== exp_w) begin
          fails++;
          $display("ERROR cfg_rdata expected %h seen %h", exp_w, cfg_rdata);
        end
      end
    end
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      $display("ERROR run_length expected below 5000 seen %0d", cyc);
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    downstream_pin = 1'b1;
    preload_wr = 1'b0;
    preload_addr = 12'h000;
    preload_data = 32'h0000_0000;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 12'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
    link_evt = '0;
    link_evt.train_busy = 1'b1;
    fails = 0;
    n_checks = 0;
    cyc = 0;
    rnd_r = 32'h0000_237f;
    @(posedge sys_clk);
    reset_chk();
    // Training outcome, speed and width capture
    ev(1'b1, 1'b0, 4'h2, 6'h08);
    terr = 1'b1;
    rd(12'h0d0, lw());
    ev(1'b0, 1'b1, 4'h3, 6'h00);
    terr = 1'b0;
    rd(12'h0d0, lw());
    rnd_r = xs(rnd_r);
    ev(1'b0, 1'b1, 4'h1, rnd_r[5:0] | 6'h01);
    sp = 4'h1;
    wd = rnd_r[5:0] | 6'h01;
    rd(12'h0d0, lw());
    ev(1'b0, 1'b1, 4'h2, 6'h10);
    sp = 4'h2;
    wd = 6'h10;
    rd(12'h0d0, lw());
    ev(1'b1, 1'b1, 4'h2, 6'h10);
    terr = 1'b1;
    link_evt.train_busy <= 1'b0;
    link_evt.dl_active <= 1'b1;
    idle();
    trn = 1'b0;
    dla = 1'b1;
    rd(12'h0d0, lw());
    idle();
    done("training");
    // Bandwidth bits and ignored writes
    link_evt.bw_mgmt_evt <= 1'b1;
    link_evt.bw_auto_evt <= 1'b1;
    tick(1);
    idle();
    bwm = 1'b1;
    bwa = 1'b1;
    rd(12'h0d0, lw());
    idle();
    wr(12'h0d0, 4'h7, 32'hffff_ffff);
    rd(12'h0d0, lw());
    idle();
    wr(12'h0d0, 4'h8, 32'h4000_0000);
    bwm = 1'b0;
    rd(12'h0d0, lw());
    idle();
    wr(12'h0d0, 4'h8, 32'hbfff_ffff);
    wr(12'h0d4, 4'hf, 32'h0000_0000);
    bwa = 1'b0;
    rd(12'h0d0, lw());
    rd(12'h0d4, {25'h0, cap});
    idle();
    // Event and clear in one cycle, event wins
    link_evt.bw_mgmt_evt <= 1'b1;
    wr(12'h0d0, 4'h8, 32'h4000_0000);
    bwm = 1'b1;
    rd(12'h0d0, lw());
    idle();
    done("bandwidth");
    // Preload of defaults
    pl(12'h0d0, 32'h0000_0000);
    sclk = 1'b0;
    rd(12'h0d0, lw());
    idle();
    rnd_r = xs(rnd_r);
    pl(12'h0d4, {25'h0, rnd_r[6:0]});
    pl(12'h0d8, 32'hffff_ffff);
    cap = rnd_r[6:0];
    rd(12'h0d4, {25'h0, cap});
    rd(12'h0d0, lw());
    idle();
    done("preload");
    // Upstream role hides slot capabilities
    downstream_pin <= 1'b0;
    tick(6);
    rd(12'h0d4, 32'h0000_0000);
    idle();
    downstream_pin <= 1'b1;
    tick(6);
    rd(12'h0d4, {25'h0, cap});
    idle();
    done("role");
    reset_chk();
    tick(3);
    stop_test();
  end
endmodule
